// ===== design/nand_ecc_pkg.sv
`default_nettype none
package nand_ecc_pkg;

  // register byte addresses
  localparam logic [11:0] CFG_ADDR       = 12'h068;
  localparam logic [11:0] EXP_LOW_ADDR   = 12'h06c;
  localparam logic [11:0] EXP_MID_ADDR   = 12'h070;
  localparam logic [11:0] EXP_HIGH_ADDR  = 12'h074;
  localparam logic [11:0] GEN_LOW_ADDR   = 12'h078;
  localparam logic [11:0] GEN_MID_ADDR   = 12'h07c;
  localparam logic [11:0] GEN_HIGH_ADDR  = 12'h080;
  localparam logic [11:0] STATUS_ADDR    = 12'h084;

  // configuration fields
  localparam int          ENABLE_BIT     = 0;
  localparam int          CORRECT_BIT    = 1;
  localparam int          PRECOMP_BIT    = 2;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;

  // block and check geometry
  localparam int          CHECK_BYTES    = 9;
  localparam int          CHECK_W        = 72;
  localparam int          IDX_W          = 9;
  localparam logic [8:0]  BLOCK_LAST     = 9'h1ff;
  localparam logic [8:0]  IDX_ZERO       = 9'h000;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [71:0] CHECK_ZERO     = 72'h0;

  // read result encodings
  localparam logic [1:0]  RES_CLEAN      = 2'h0;
  localparam logic [1:0]  RES_CORR       = 2'h1;
  localparam logic [1:0]  RES_UNCORR     = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRECOMP,
    ST_WRITE,
    ST_READ,
    ST_DECODE,
    ST_RELOAD
  } ecc_state_t;

endpackage
`default_nettype wire

// ===== design/check_accum.sv
`timescale 1ns/1ns
`default_nettype none
// byte j<8 gathers bytes whose index bit j is set, upper half rotated
// so the index msb can be recovered; byte 8 gathers every byte
module check_accum (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [8:0]  idx,
  input  wire logic [7:0]  data,
  output logic      [71:0] check
);
  logic [7:0] rot;

  assign rot = idx[8] ? {data[6:0], data[7]} : data;

  genvar j;
  for (j = 0; j < nand_ecc_pkg::CHECK_BYTES; j++) begin : g_byte
    always_ff @(posedge clk) begin
      if (srst || clear) begin
        check[8*j +: 8] <= nand_ecc_pkg::BYTE_ZERO;
      end else if (en) begin
        if (j == nand_ecc_pkg::CHECK_BYTES - 1) begin
          check[8*j +: 8] <= check[8*j +: 8] ^ data;
        end else if (idx[j]) begin
          check[8*j +: 8] <= check[8*j +: 8] ^ rot;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/block_store.sv
`timescale 1ns/1ns
`default_nettype none
// holds one read block so a corrected copy can be replayed
module block_store (
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [8:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [8:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:511];

  // no reset: contents are only read after a full block is stored
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ===== design/nand_block_reed_solomon_ecc.sv
// What this block does
// RL1: bit 0 of the config register enables checking and generation, else data bypasses.
// RL2: bit 2 of the config register is a self-clearing pre-compute trigger.
// RL3: pre-compute pulls 512 bytes from the transmit fifo and sends none to flash.
// RL4: after pre-compute the 9 generated check bytes are readable in the generated registers.
// RL5: a following block write refills the same 512 bytes and this pass goes to flash.
// RL6: bit 1 is a self-clearing correction trigger, used after correctable errors.
// RL7: the correction trigger reloads the input fifo with the corrected 512-byte block.
// RL8: software loads the 9 expected check bytes before each block read.
// RL9: expected parity is split 31:0, 63:32 and 71:64 in the low byte of the third word.
// RL10: generated parity is read-only with the same three-word split.
// RL11: check bytes are generated whenever a 512-byte block is written to flash with bit 0 set.
// RL12: each block read with bit 0 set ends in a done pulse and a 2-bit result: 00 clean, 01 fixable, 1x not.
// RL13: pre-compute issues no flash traffic and generated parity holds until the next pass.
`timescale 1ns/1ns
`default_nettype none
module nand_block_reed_solomon_ecc (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        blk_write_start,
  input  wire logic        blk_read_start,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  output logic             tx_pop,
  output logic      [7:0]  flash_wr_byte,
  output logic             flash_wr_valid,
  input  wire logic        flash_wr_ready,
  input  wire logic [7:0]  flash_rd_byte,
  input  wire logic        flash_rd_valid,
  output logic      [7:0]  rx_byte,
  output logic             rx_push,
  input  wire logic        rx_ready,
  output logic             read_check_done,
  output logic      [1:0]  read_check_result,
  output logic             code_check_enable,
  output logic             busy
);
  nand_ecc_pkg::ecc_state_t state;

  logic [71:0] expected;
  logic [71:0] generated;
  logic [71:0] acc;
  logic [8:0]  idx;
  logic        acc_en;
  logic        acc_clear;
  logic [7:0]  acc_byte;
  logic [8:0]  fix_loc;
  logic [7:0]  fix_val;
  logic        fetched;
  logic [7:0]  store_q;
  logic        access;
  logic        wr_acc;
  logic        precomp_go;
  logic        correct_go;
  logic        pass_last;
  logic        publish;

  // apb: one wait state, pready and read data both registered; writes
  // commit at the edge that completes the transfer
  assign access = psel && penable && !pready;
  assign wr_acc = psel && penable && pready && pwrite;
  assign precomp_go = wr_acc && paddr == nand_ecc_pkg::CFG_ADDR
                      && pwdata[nand_ecc_pkg::PRECOMP_BIT];
  assign correct_go = wr_acc && paddr == nand_ecc_pkg::CFG_ADDR
                      && pwdata[nand_ecc_pkg::CORRECT_BIT];

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= nand_ecc_pkg::REG_RESET;
    end else begin
      pready  <= access;
      pslverr <= 1'b0;
      prdata  <= nand_ecc_pkg::REG_RESET;
      if (access) begin
        case (paddr)
          nand_ecc_pkg::CFG_ADDR: begin
            // trigger bits read back as zero: they self-clear
            prdata[nand_ecc_pkg::ENABLE_BIT] <= code_check_enable; // [RL2] [RL6]
          end
          nand_ecc_pkg::EXP_LOW_ADDR:  prdata <= expected[31:0];
          nand_ecc_pkg::EXP_MID_ADDR:  prdata <= expected[63:32];
          nand_ecc_pkg::EXP_HIGH_ADDR: prdata[7:0] <= expected[71:64]; // [RL9]
          nand_ecc_pkg::GEN_LOW_ADDR: begin
            prdata  <= generated[31:0];
            pslverr <= pwrite;
          end
          nand_ecc_pkg::GEN_MID_ADDR: begin
            prdata  <= generated[63:32];
            pslverr <= pwrite;
          end
          nand_ecc_pkg::GEN_HIGH_ADDR: begin
            prdata[7:0] <= generated[71:64]; // [RL10]
            pslverr     <= pwrite;
          end
          nand_ecc_pkg::STATUS_ADDR: begin
            prdata[1:0] <= read_check_result;
            pslverr     <= pwrite;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // software-written registers
  always_ff @(posedge clk) begin
    if (srst) begin
      code_check_enable <= 1'b0;
      expected          <= nand_ecc_pkg::CHECK_ZERO;
    end else if (wr_acc) begin
      case (paddr)
        nand_ecc_pkg::CFG_ADDR:
          code_check_enable <= pwdata[nand_ecc_pkg::ENABLE_BIT]; // [RL1]
        nand_ecc_pkg::EXP_LOW_ADDR:  expected[31:0]  <= pwdata;
        nand_ecc_pkg::EXP_MID_ADDR:  expected[63:32] <= pwdata;
        nand_ecc_pkg::EXP_HIGH_ADDR: expected[71:64] <= pwdata[7:0]; // [RL9]
        default: ;
      endcase
    end
  end

  assign pass_last = idx == nand_ecc_pkg::BLOCK_LAST;

  // sequencing; triggers while busy are ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= nand_ecc_pkg::ST_IDLE;
    end else begin
      case (state)
        nand_ecc_pkg::ST_IDLE: begin
          if (precomp_go && code_check_enable) begin
            state <= nand_ecc_pkg::ST_PRECOMP; // [RL2]
          end else if (correct_go && read_check_result == nand_ecc_pkg::RES_CORR) begin
            state <= nand_ecc_pkg::ST_RELOAD; // [RL6]
          end else if (blk_write_start) begin
            state <= nand_ecc_pkg::ST_WRITE; // [RL5]
          end else if (blk_read_start) begin
            state <= nand_ecc_pkg::ST_READ;
          end
        end
        nand_ecc_pkg::ST_PRECOMP, nand_ecc_pkg::ST_WRITE: begin
          if (tx_pop && pass_last) begin
            state <= nand_ecc_pkg::ST_IDLE;
          end
        end
        nand_ecc_pkg::ST_READ: begin
          if (flash_rd_valid && pass_last) begin
            state <= code_check_enable ? nand_ecc_pkg::ST_DECODE
                                       : nand_ecc_pkg::ST_IDLE; // [RL1]
          end
        end
        nand_ecc_pkg::ST_DECODE: state <= nand_ecc_pkg::ST_IDLE;
        nand_ecc_pkg::ST_RELOAD: begin
          if (fetched && pass_last) begin
            state <= nand_ecc_pkg::ST_IDLE;
          end
        end
        default: state <= nand_ecc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= state != nand_ecc_pkg::ST_IDLE;
    end
  end

  // byte index within the block, advanced per byte moved
  always_ff @(posedge clk) begin
    if (srst || state == nand_ecc_pkg::ST_IDLE) begin
      idx <= nand_ecc_pkg::IDX_ZERO;
    end else if (tx_pop || (state == nand_ecc_pkg::ST_READ && flash_rd_valid)
                 || (state == nand_ecc_pkg::ST_RELOAD && fetched)) begin
      idx <= idx + 9'h001;
    end
  end

  // transmit fifo pops: one every other cycle at most; a write pass
  // waits for the flash slot to drain, which is how flash back-pressure
  // reaches the fifo
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_pop <= 1'b0;
    end else begin
      tx_pop <= 1'b0;
      if (!tx_pop && tx_valid && !(tx_pop && pass_last)) begin
        if (state == nand_ecc_pkg::ST_PRECOMP) begin
          tx_pop <= 1'b1; // [RL3]
        end else if (state == nand_ecc_pkg::ST_WRITE && !flash_wr_valid) begin
          tx_pop <= 1'b1; // [RL5]
        end
      end
    end
  end

  // flash write slot: only a write pass loads it
  always_ff @(posedge clk) begin
    if (srst) begin
      flash_wr_valid <= 1'b0;
      flash_wr_byte  <= nand_ecc_pkg::BYTE_ZERO;
    end else if (tx_pop && state == nand_ecc_pkg::ST_WRITE) begin
      flash_wr_valid <= 1'b1; // [RL5] [RL13]
      flash_wr_byte  <= tx_byte;
    end else if (flash_wr_ready) begin
      flash_wr_valid <= 1'b0;
    end
  end

  // check accumulation on pre-compute, write and read passes while enabled
  assign acc_clear = state == nand_ecc_pkg::ST_IDLE;
  assign acc_byte  = state == nand_ecc_pkg::ST_READ ? flash_rd_byte : tx_byte;
  assign acc_en    = code_check_enable && (tx_pop
                     || (state == nand_ecc_pkg::ST_READ && flash_rd_valid));

  check_accum u_accum (
    .clk   (clk),
    .srst  (srst),
    .clear (acc_clear),
    .en    (acc_en),
    .idx   (idx),
    .data  (acc_byte),
    .check (acc)
  );

  // publish only when a whole block went through, so the registers stay
  // stable between passes and an aborted pass never shows a partial sum
  always_ff @(posedge clk) begin
    if (srst) begin
      publish   <= 1'b0;
      generated <= nand_ecc_pkg::CHECK_ZERO;
    end else begin
      // last byte enters the sum at the same edge, so publish one later
      publish <= code_check_enable && tx_pop && pass_last;
      if (publish) begin
        generated <= acc; // [RL4] [RL11] [RL13]
      end
    end
  end

  block_store u_store (
    .clk   (clk),
    .we    (state == nand_ecc_pkg::ST_READ && flash_rd_valid),
    .waddr (idx),
    .wdata (flash_rd_byte),
    .raddr (idx),
    .rdata (store_q)
  );

  // syndrome decode: a single bad byte at index i with value e leaves
  // e in byte 8 and e (or e rotated, upper half) where bit j of i is set
  logic [71:0] syn;
  logic [7:0]  syn_val;
  logic [7:0]  syn_rot;
  logic        same_e;
  logic        same_r;
  logic        any_loc;
  logic [7:0]  loc_bits;

  assign syn     = acc ^ expected; // [RL8]
  assign syn_val = syn[71:64];
  assign syn_rot = {syn_val[6:0], syn_val[7]};

  always_comb begin
    same_e   = 1'b1;
    same_r   = 1'b1;
    loc_bits = nand_ecc_pkg::BYTE_ZERO;
    for (int j = 0; j < nand_ecc_pkg::CHECK_BYTES - 1; j++) begin
      loc_bits[j] = syn[8*j +: 8] != nand_ecc_pkg::BYTE_ZERO;
      if (loc_bits[j] && syn[8*j +: 8] != syn_val) begin
        same_e = 1'b0;
      end
      if (loc_bits[j] && syn[8*j +: 8] != syn_rot) begin
        same_r = 1'b0;
      end
    end
    any_loc = |loc_bits;
  end

  // index 0/256 and the value ff cannot be located and count as not fixable
  always_ff @(posedge clk) begin
    if (srst) begin
      read_check_result <= nand_ecc_pkg::RES_CLEAN;
      read_check_done   <= 1'b0;
      fix_loc           <= nand_ecc_pkg::IDX_ZERO;
      fix_val           <= nand_ecc_pkg::BYTE_ZERO;
    end else begin
      read_check_done <= 1'b0;
      if (state == nand_ecc_pkg::ST_DECODE) begin
        read_check_done <= 1'b1; // [RL12]
        fix_loc         <= {same_r, loc_bits};
        fix_val         <= syn_val;
        if (syn == nand_ecc_pkg::CHECK_ZERO) begin
          read_check_result <= nand_ecc_pkg::RES_CLEAN;
        end else if (syn_val != nand_ecc_pkg::BYTE_ZERO && any_loc
                     && (same_e ^ same_r)) begin
          read_check_result <= nand_ecc_pkg::RES_CORR;
        end else begin
          read_check_result <= nand_ecc_pkg::RES_UNCORR;
        end
      end
    end
  end

  // receive fifo feed: straight from flash on a read pass, from the
  // stored block on reload (three cycles per byte for the array read and push)
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_push <= 1'b0;
      rx_byte <= nand_ecc_pkg::BYTE_ZERO;
      fetched <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (state == nand_ecc_pkg::ST_READ && flash_rd_valid) begin
        rx_push <= 1'b1;
        rx_byte <= flash_rd_byte;
      end else if (state == nand_ecc_pkg::ST_RELOAD) begin
        if (fetched) begin
          fetched <= 1'b0;
          rx_push <= 1'b1;
          rx_byte <= idx == fix_loc ? store_q ^ fix_val : store_q; // [RL7]
        end else if (rx_ready && !rx_push) begin
          fetched <= 1'b1;
        end
      end else begin
        fetched <= 1'b0;
      end
    end
  end

  // checks
  sequence s_pop_in_write;
    tx_pop && state == nand_ecc_pkg::ST_WRITE;
  endsequence

  sequence s_slot_loaded;
    flash_wr_valid && flash_wr_byte == $past(tx_byte);
  endsequence

  sequence s_decode_step;
    state == nand_ecc_pkg::ST_DECODE;
  endsequence

  a_trigger_reads_zero: assert property (@(posedge clk) disable iff (srst) // [RL2] [RL6]
    pready && !pwrite && paddr == nand_ecc_pkg::CFG_ADDR |-> prdata[2:1] == 2'h0)
    else $error("trigger bits read back as one");

  a_precomp_no_flash: assert property (@(posedge clk) disable iff (srst) // [RL13]
    state == nand_ecc_pkg::ST_PRECOMP && !$past(flash_wr_valid) |-> !flash_wr_valid)
    else $error("flash traffic during pre-compute");

  a_precomp_full_block: assert property (@(posedge clk) disable iff (srst) // [RL3]
    $past(state) == nand_ecc_pkg::ST_PRECOMP && state == nand_ecc_pkg::ST_IDLE
    |-> $past(idx) == nand_ecc_pkg::BLOCK_LAST && $past(tx_pop))
    else $error("pre-compute ended before 512 bytes");

  a_parity_publish: assert property (@(posedge clk) disable iff (srst) // [RL4] [RL11]
    publish |=> generated == $past(acc))
    else $error("generated parity not published at block end");

  a_parity_stable: assert property (@(posedge clk) disable iff (srst) // [RL13]
    state == nand_ecc_pkg::ST_IDLE && !publish |=> $stable(generated))
    else $error("generated parity moved between passes");

  a_bypass_no_gen: assert property (@(posedge clk) disable iff (srst) // [RL1]
    !code_check_enable && !$past(code_check_enable) |-> $stable(generated) && !read_check_done)
    else $error("engine active while disabled");

  a_write_forward: assert property (@(posedge clk) disable iff (srst) // [RL5]
    s_pop_in_write |=> s_slot_loaded)
    else $error("written byte not forwarded to flash");

  a_done_after_read: assert property (@(posedge clk) disable iff (srst) // [RL12]
    (($past(state) == nand_ecc_pkg::ST_READ) and s_decode_step)
    |=> read_check_done ##1 !read_check_done)
    else $error("read check done not a single pulse after read");

  a_expected_high: assert property (@(posedge clk) disable iff (srst) // [RL9]
    wr_acc && paddr == nand_ecc_pkg::EXP_HIGH_ADDR |=> expected[71:64] == $past(pwdata[7:0]))
    else $error("expected parity high byte not stored");

  a_gen_high_read: assert property (@(posedge clk) disable iff (srst) // [RL10]
    pready && !pwrite && paddr == nand_ecc_pkg::GEN_HIGH_ADDR
    |-> prdata == {24'h000000, generated[71:64]})
    else $error("generated parity high word misread");

  a_reload_len: assert property (@(posedge clk) disable iff (srst) // [RL7]
    $past(state) == nand_ecc_pkg::ST_RELOAD && state == nand_ecc_pkg::ST_IDLE
    |-> rx_push && $past(idx) == nand_ecc_pkg::BLOCK_LAST)
    else $error("reload did not replay the whole block");

endmodule
`default_nettype wire

// ===== verif/nand_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// transmit fifo head, flash array and receive side as the engine sees them
module nand_far_side_model (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       tx_fill,
  input  wire logic       rd_go,
  input  wire logic [9:0] bad_idx,
  input  wire logic       tx_pop,
  output logic      [7:0] tx_byte,
  output logic            tx_valid,
  input  wire logic [7:0] flash_wr_byte,
  input  wire logic       flash_wr_valid,
  output logic            flash_wr_ready,
  output logic      [7:0] flash_rd_byte,
  output logic            flash_rd_valid,
  output logic            rx_ready,
  output int              wr_n,
  output int              wr_bad
);
  logic [9:0] ti;
  logic [9:0] ri;
  logic       ph;
  logic [7:0] junk;
  logic [7:0] flip;

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction

  // idle lines toggle so a stale byte never passes for data
  assign junk           = 8'h5a ^ {8{ph}};
  assign tx_valid       = (ti < 10'd512);
  assign tx_byte        = tx_valid ? pat(int'(ti)) : junk;
  assign flash_wr_ready = ~slow | ph;
  assign rx_ready       = ~slow | ~ph;
  assign flash_rd_valid = (ri < 10'd512) && (~slow | ph);
  assign flip           = (ri == bad_idx) ? 8'h10 : 8'h00;
  assign flash_rd_byte  = flash_rd_valid ? (pat(int'(ri)) ^ flip) : junk;

  always @(posedge clk) begin
    ph <= ~ph;
    if (tx_pop && tx_valid) ti <= ti + 10'h001;
    if (flash_wr_valid && flash_wr_ready) begin
      wr_n <= wr_n + 1;
      if (flash_wr_byte !== pat(wr_n)) wr_bad <= wr_bad + 1;
    end
    if (flash_rd_valid) ri <= ri + 10'h001;
    if (rd_go) ri <= 10'h000;
    if (tx_fill) ti <= 10'h000;
    if (tx_fill) wr_n <= 0;
    if (srst) begin
      ph     <= 1'b0;
      ti     <= 10'h000;
      ri     <= 10'd512;
      wr_n   <= 0;
      wr_bad <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== verif/nand_block_reed_solomon_ecc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nand_block_reed_solomon_ecc_tb_top;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        blk_write_start, blk_read_start, tx_valid, tx_pop, flash_wr_valid;
  logic        flash_wr_ready, flash_rd_valid, rx_push, rx_ready, read_check_done;
  logic        code_check_enable, busy, slow, tx_fill, rd_go, er;
  logic [7:0]  tx_byte, flash_wr_byte, flash_rd_byte, rx_byte;
  logic [1:0]  read_check_result;
  logic [9:0]  bad_idx;
  logic [71:0] golden;
  logic [7:0]  rx_mem [512];
  int          wr_n, wr_bad, err_count, num_checks, pop_n, fv_n, rx_n, done_n, p0, f0, r0;

  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  localparam row_t ROWS [11] = '{
    '{1'b0, nand_ecc_pkg::EXP_LOW_ADDR, 32'h0, 32'h0000_0000, 1'b0},
    '{1'b0, nand_ecc_pkg::GEN_LOW_ADDR, 32'h0, 32'h0000_0000, 1'b0},
    '{1'b0, nand_ecc_pkg::STATUS_ADDR, 32'h0, 32'h0000_0000, 1'b0},
    '{1'b0, nand_ecc_pkg::CFG_ADDR, 32'h0, 32'h0000_0000, 1'b0},
    '{1'b1, nand_ecc_pkg::EXP_MID_ADDR, 32'h1234_5678, 32'h0, 1'b0},
    '{1'b0, nand_ecc_pkg::EXP_MID_ADDR, 32'h0, 32'h1234_5678, 1'b0},
    '{1'b1, nand_ecc_pkg::EXP_HIGH_ADDR, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b0, nand_ecc_pkg::EXP_HIGH_ADDR, 32'h0, 32'h0000_00ff, 1'b0},
    '{1'b1, nand_ecc_pkg::GEN_MID_ADDR, 32'h0000_0001, 32'h0, 1'b1},
    '{1'b0, nand_ecc_pkg::GEN_MID_ADDR, 32'h0, 32'h0000_0000, 1'b0},
    '{1'b0, 12'h100, 32'h0, 32'h0000_0000, 1'b1}};

  nand_block_reed_solomon_ecc dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .blk_write_start(blk_write_start), .blk_read_start(blk_read_start), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_pop(tx_pop), .flash_wr_byte(flash_wr_byte),
    .flash_wr_valid(flash_wr_valid), .flash_wr_ready(flash_wr_ready),
    .flash_rd_byte(flash_rd_byte), .flash_rd_valid(flash_rd_valid), .rx_byte(rx_byte),
    .rx_push(rx_push), .rx_ready(rx_ready), .read_check_done(read_check_done),
    .read_check_result(read_check_result), .code_check_enable(code_check_enable), .busy(busy));

  nand_far_side_model far (
    .clk(clk), .srst(srst), .slow(slow), .tx_fill(tx_fill), .rd_go(rd_go), .bad_idx(bad_idx),
    .tx_pop(tx_pop), .tx_byte(tx_byte), .tx_valid(tx_valid), .flash_wr_byte(flash_wr_byte),
    .flash_wr_valid(flash_wr_valid), .flash_wr_ready(flash_wr_ready),
    .flash_rd_byte(flash_rd_byte), .flash_rd_valid(flash_rd_valid), .rx_ready(rx_ready),
    .wr_n(wr_n), .wr_bad(wr_bad));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_pop) pop_n <= pop_n + 1;
    if (flash_wr_valid) fv_n <= fv_n + 1;
    if (read_check_done) done_n <= done_n + 1;
    if (rx_push) rx_mem[rx_n % 512] <= rx_byte;
    if (rx_push) rx_n <= rx_n + 1;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction

  // byte 8 sums all bytes, byte j those with index bit j, upper half rotated
  function automatic logic [71:0] calc();
    logic [71:0] c;
    logic [7:0]  b;
    c = nand_ecc_pkg::CHECK_ZERO;
    for (int i = 0; i < 512; i++) begin
      b = pat(i);
      c[71:64] ^= b;
      if (i >= 256) b = {b[6:0], b[7]};
      for (int j = 0; j < 8; j++) if (i[j]) c[8*j +: 8] ^= b;
    end
    return c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fail_out(input string msg);
    err_count++;
    $display("Error at %0t: %s", $time, msg);
    test_done();
  endtask

  // caller sits just after a rising edge; one idle cycle follows release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 16) fail_out("no apb answer");
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) fail_out("engine stuck busy");
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse_fill();
    tx_fill <= 1'b1;
    @(posedge clk);
    tx_fill <= 1'b0;
  endtask

  task automatic chk_gen(input logic [71:0] c);
    apb(1'b0, nand_ecc_pkg::GEN_LOW_ADDR, 32'h0);
    chk(rd, c[31:0]);
    apb(1'b0, nand_ecc_pkg::GEN_MID_ADDR, 32'h0);
    chk(rd, c[63:32]);
    apb(1'b0, nand_ecc_pkg::GEN_HIGH_ADDR, 32'h0);
    chk(rd, {24'h00_0000, c[71:64]});
  endtask

  task automatic read_block(input logic [9:0] bi, input logic [1:0] res);
    int d0;
    d0 = done_n;
    bad_idx        <= bi;
    blk_read_start <= 1'b1;
    @(posedge clk);
    blk_read_start <= 1'b0;
    rd_go          <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    wait_idle();
    chk(32'(done_n - d0), 32'h1);
    chk(32'(read_check_result), 32'(res));
    apb(1'b0, nand_ecc_pkg::STATUS_ADDR, 32'h0);
    chk(rd, 32'(res));
  endtask

  initial begin
    {srst, slow} = 2'b10;
    {psel, penable, pwrite, blk_write_start, blk_read_start, tx_fill, rd_go} = 7'h00;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    bad_idx = 10'h3ff;
    golden  = calc();
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(32'({busy, tx_pop, flash_wr_valid, rx_push, code_check_enable}), 32'h0);
    foreach (ROWS[i]) begin
      apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      chk(32'(er), 32'(ROWS[i].e));
      if (!ROWS[i].w) chk(rd, ROWS[i].q);
    end
    // trigger while the engine is off must do nothing
    p0 = pop_n;
    apb(1'b1, nand_ecc_pkg::CFG_ADDR, 32'h4);
    repeat (20) @(posedge clk);
    chk(32'(pop_n - p0), 32'h0);
    apb(1'b1, nand_ecc_pkg::CFG_ADDR, 32'h1);
    chk(32'(code_check_enable), 32'h1);
    // pre-compute pass against a slow far side
    slow <= 1'b1;
    pulse_fill();
    f0 = fv_n;
    apb(1'b1, nand_ecc_pkg::CFG_ADDR, 32'h5);
    apb(1'b0, nand_ecc_pkg::CFG_ADDR, 32'h0);
    chk(rd, 32'h1);
    wait_idle();
    chk(32'(pop_n - p0), 32'd512);
    chk(32'(fv_n - f0), 32'h0);
    chk_gen(golden);
    pulse_fill();
    blk_write_start <= 1'b1;
    @(posedge clk);
    blk_write_start <= 1'b0;
    wait_idle();
    chk(32'(wr_n), 32'd512);
    chk(32'(wr_bad), 32'h0);
    chk_gen(golden);
    apb(1'b1, nand_ecc_pkg::EXP_LOW_ADDR, golden[31:0]);
    apb(1'b1, nand_ecc_pkg::EXP_MID_ADDR, golden[63:32]);
    apb(1'b1, nand_ecc_pkg::EXP_HIGH_ADDR, {24'h00_0000, golden[71:64]});
    read_block(10'h3ff, nand_ecc_pkg::RES_CLEAN);
    r0 = rx_n;
    read_block(10'd5, nand_ecc_pkg::RES_CORR);
    chk(32'(rx_mem[5]), 32'(pat(5) ^ 8'h10));
    apb(1'b1, nand_ecc_pkg::CFG_ADDR, 32'h3);
    wait_idle();
    chk(32'(rx_n - r0), 32'd1024);
    chk(32'(rx_mem[5]), 32'(pat(5)));
    chk(32'(rx_mem[511]), 32'(pat(511)));
    chk_gen(golden);
    // mid-run reset clears the engine and the published parity
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(32'({busy, tx_pop, flash_wr_valid, rx_push, code_check_enable}), 32'h0);
    chk_gen(nand_ecc_pkg::CHECK_ZERO);
    test_done();
  end
endmodule
`default_nettype wire
